/* File: design/gsd_params.svh */
/*
 gsd_params.svh: offsets, field positions and reset values of the pin configuration block.
 assumes a classic wishbone slave with 32-bit data and word-aligned byte addresses.
*/
`ifndef GSD_PARAMS_SVH
`define GSD_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GSD_OFS_GPIO_OE     8'h00
`define GSD_OFS_GPIO_OUT    8'h04
`define GSD_OFS_GPIO_IN     8'h08
`define GSD_OFS_STRAP       8'h0c
`define GSD_OFS_CTRL        8'h10

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define GSD_GPIO_W          8
`define GSD_NPORT           3
`define GSD_SMB_LSB         5
`define GSD_SMB_W           3
`define GSD_DBG_W           5
`define GSD_STRAP_PWR_BIT   0
`define GSD_STRAP_DBG_BIT   1
`define GSD_STRAP_SMB_LSB   4
`define GSD_STRAP_DSEL_LSB  8
`define GSD_CTRL_SMB_BIT    0
`define GSD_OE_RST          8'h00
`define GSD_OUT_RST         8'h00
`define GSD_CTRL_RST        1'b0

`endif

/* File: design/gsd_pkg.sv */
/*
 gsd_pkg.sv: types shared by the pin configuration block.
 assumes gsd_params.svh sits on the include path.
*/
`include "gsd_params.svh"

package gsd_pkg;

    // ----------------------------------------
    // wishbone request and answer
    // ----------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gsd_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gsd_wb_rsp_t;

    // ----------------------------------------
    // settings latched at reset release
    // ----------------------------------------
    typedef struct packed {
        logic                         pwr_save;
        logic                         debug_mode;
        logic [`GSD_SMB_W-1:0]        smb_addr;
        logic [`GSD_DBG_W-1:0]        debug_sel;
    } gsd_strap_t;

    typedef enum logic [1:0] {
        GSD_ST_RESET = 2'b00,
        GSD_ST_SAMPLE = 2'b01,
        GSD_ST_RUN   = 2'b10
    } gsd_state_t;

endpackage

/* File: design/gsd_pin_cfg.sv */
/*
 gsd_pin_cfg.sv: general pins, strap capture, debug mode and port status gating of a packet switch.
 assumes one 200 MHz clock, synchronous active-high reset and a classic wishbone master.
*/
// Behaviour
// - each general pin is input-only or bidirectional per a software direction register bit; pins 7..5 forced input with bus in use, 4..0 in debug mode
// - with management bus in use, pins 7..5 give its address bits 2..0
// - in debug mode pins 4..0 select which debug mode is active
// - in debug mode port status pins driven only while the status enable input is high
// - debug mode entered when the debug enable input is low; high is normal
// - one port status output per port 0 to 2, showing that port's status
`timescale 1ns/100ps
`include "gsd_params.svh"

module gsd_pin_cfg #(
    parameter int GPIO_W = `GSD_GPIO_W,
    parameter int NPORT  = `GSD_NPORT
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire gsd_pkg::gsd_wb_req_t wb_req_i,
    output gsd_pkg::gsd_wb_rsp_t     wb_rsp_o,
    input  wire logic [GPIO_W-1:0]   gpio_i,
    output logic      [GPIO_W-1:0]   gpio_o,
    output logic      [GPIO_W-1:0]   gpio_oe_o,
    input  wire logic                power_saving_strap_i,
    input  wire logic                debug_enable_input_i,
    input  wire logic                port_status_output_enable_i,
    input  wire logic [NPORT-1:0]    port_status_i,
    output logic      [NPORT-1:0]    port_status_out_o,
    output logic      [NPORT-1:0]    port_status_out_oe_o,
    output gsd_pkg::gsd_strap_t      strap_o
);
    import gsd_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int SW = GPIO_W + 3;
    logic [SW-1:0] sync1_r, sync2_r;
    always_ff @(posedge clk_i) begin
        sync1_r <= {power_saving_strap_i, debug_enable_input_i, port_status_output_enable_i, gpio_i};
        sync2_r <= sync1_r;
    end
    logic [GPIO_W-1:0] gpio_s;
    logic              pwr_s, dbg_n_s, pse_s;
    assign gpio_s  = sync2_r[GPIO_W-1:0];
    assign pse_s   = sync2_r[GPIO_W];
    assign dbg_n_s = sync2_r[GPIO_W+1];
    assign pwr_s   = sync2_r[GPIO_W+2];

    // ----------------------------------------
    // strap capture
    // ----------------------------------------
    // the synchroniser needs two edges to fill, so capture waits for the release
    // and then takes the pin level the board held through reset
    gsd_state_t st_r, st_nxt;
    gsd_strap_t strap_r, strap_nxt;
    always_comb begin
        st_nxt    = st_r;
        strap_nxt = strap_r;
        case (st_r)
            GSD_ST_RESET:  st_nxt = GSD_ST_SAMPLE;
            GSD_ST_SAMPLE: begin
                strap_nxt.pwr_save   = pwr_s;
                strap_nxt.debug_mode = ~dbg_n_s;
                strap_nxt.smb_addr   = gpio_s[`GSD_SMB_LSB +: `GSD_SMB_W];
                strap_nxt.debug_sel  = gpio_s[`GSD_DBG_W-1:0];
                st_nxt               = GSD_ST_RUN;
            end
            GSD_ST_RUN:    st_nxt = GSD_ST_RUN;
            default:       st_nxt = GSD_ST_RESET;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r    <= GSD_ST_RESET;
            strap_r <= '0;
        end else begin
            st_r    <= st_nxt;
            strap_r <= strap_nxt;
        end
    end
    assign strap_o = strap_r;

    // ----------------------------------------
    // registers and wishbone slave
    // ----------------------------------------
    logic [GPIO_W-1:0] oe_r, oe_nxt, out_r, out_nxt;
    logic              smb_en_r, smb_en_nxt, ack_r, ack_nxt;
    logic [31:0]       rdat_r, rdat_nxt;
    logic              wr;
    // a write lands on the edge at which the master samples ack high, while its request still stands
    assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_r & wb_req_i.sel[0];
    always_comb begin
        oe_nxt     = oe_r;
        out_nxt    = out_r;
        smb_en_nxt = smb_en_r;
        ack_nxt    = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
        rdat_nxt   = 32'h0000_0000;
        if (wr && wb_req_i.adr == `GSD_OFS_GPIO_OE)
            oe_nxt = wb_req_i.dat[GPIO_W-1:0];
        if (wr && wb_req_i.adr == `GSD_OFS_GPIO_OUT)
            out_nxt = wb_req_i.dat[GPIO_W-1:0];
        if (wr && wb_req_i.adr == `GSD_OFS_CTRL)
            smb_en_nxt = wb_req_i.dat[`GSD_CTRL_SMB_BIT];
        case (wb_req_i.adr)
            `GSD_OFS_GPIO_OE:  rdat_nxt[GPIO_W-1:0] = oe_r;
            `GSD_OFS_GPIO_OUT: rdat_nxt[GPIO_W-1:0] = out_r;
            `GSD_OFS_GPIO_IN:  rdat_nxt[GPIO_W-1:0] = gpio_s;
            `GSD_OFS_STRAP: begin
                rdat_nxt[`GSD_STRAP_PWR_BIT]                   = strap_r.pwr_save;
                rdat_nxt[`GSD_STRAP_DBG_BIT]                   = strap_r.debug_mode;
                rdat_nxt[`GSD_STRAP_SMB_LSB +: `GSD_SMB_W]     = strap_r.smb_addr;
                rdat_nxt[`GSD_STRAP_DSEL_LSB +: `GSD_DBG_W]    = strap_r.debug_sel;
            end
            `GSD_OFS_CTRL:     rdat_nxt[`GSD_CTRL_SMB_BIT] = smb_en_r;
            default:           rdat_nxt = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_r     <= `GSD_OE_RST;
            out_r    <= `GSD_OUT_RST;
            smb_en_r <= `GSD_CTRL_RST;
            ack_r    <= 1'b0;
            rdat_r   <= 32'h0000_0000;
        end else begin
            oe_r     <= oe_nxt;
            out_r    <= out_nxt;
            smb_en_r <= smb_en_nxt;
            ack_r    <= ack_nxt;
            rdat_r   <= rdat_nxt;
        end
    end
    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdat_r;

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // strap pins must stay undriven while they carry address or debug selection,
    // otherwise software could fight the board straps
    logic [GPIO_W-1:0] strap_mask;
    always_comb begin
        strap_mask = '0;
        if (smb_en_r)
            strap_mask[`GSD_SMB_LSB +: `GSD_SMB_W] = '1;
        if (strap_r.debug_mode)
            strap_mask[`GSD_DBG_W-1:0] = '1;
    end
    assign gpio_o    = out_r;
    assign gpio_oe_o = oe_r & ~strap_mask;

    logic [NPORT-1:0] ps_r;
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            always_ff @(posedge clk_i) begin
                if (rst_i)
                    ps_r[p] <= 1'b0;
                else
                    ps_r[p] <= port_status_i[p];
            end
            assign port_status_out_oe_o[p] = strap_r.debug_mode & pse_s;
        end
    endgenerate
    assign port_status_out_o = ps_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_sample;
        st_r == GSD_ST_SAMPLE;
    endsequence

    AST_OE_FOLLOWS_REG: assert property (@(posedge clk_i) disable iff (rst_i)
        (!smb_en_r && !strap_r.debug_mode) |-> gpio_oe_o == oe_r)
        else $error("pin enable differs from direction register");
    AST_SMB_PINS_IN: assert property (@(posedge clk_i) disable iff (rst_i)
        smb_en_r |-> gpio_oe_o[7:5] == 3'h0)
        else $error("address pins driven while bus in use");
    AST_DBG_PINS_IN: assert property (@(posedge clk_i) disable iff (rst_i)
        strap_r.debug_mode |-> gpio_oe_o[4:0] == 5'h00)
        else $error("debug select pins driven in debug mode");
    AST_PWR_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sample |=> strap_r.pwr_save == $past(pwr_s))
        else $error("power saving strap not captured");
    AST_PS_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_status_out_oe_o != 3'h0) |-> (strap_r.debug_mode && pse_s))
        else $error("port status driven without enable");
    AST_DBG_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sample |=> strap_r.debug_mode == !$past(dbg_n_s))
        else $error("debug mode capture wrong");
    AST_PS_VALUE: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> port_status_out_o == $past(port_status_i))
        else $error("port status not following port");
    AST_STRAP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r == GSD_ST_RUN) |=> $stable(strap_r))
        else $error("strap settings changed after capture");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");

    // bus steps: a fresh request, then the write on the acknowledging edge
    sequence s_req_new;
        wb_req_i.cyc && wb_req_i.stb && !ack_r;
    endsequence

    sequence s_oe_write;
        wr && (wb_req_i.adr == `GSD_OFS_GPIO_OE);
    endsequence

    AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req_new |=> ack_r)
        else $error("request not answered in the next cycle");
    AST_OE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_oe_write |=> oe_r == $past(wb_req_i.dat[GPIO_W-1:0]))
        else $error("direction register write lost");
    AST_SMB_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sample |=> strap_r.smb_addr == $past(gpio_s[`GSD_SMB_LSB +: `GSD_SMB_W]))
        else $error("address strap not captured");
    AST_DSEL_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_sample |=> strap_r.debug_sel == $past(gpio_s[`GSD_DBG_W-1:0]))
        else $error("debug selection not captured");
    AST_PS_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        !strap_r.debug_mode |-> port_status_out_oe_o == '0)
        else $error("port status driven outside debug mode");

endmodule

/* File: dv/gsd_board_model.sv */
/*
 gsd_board_model.sv: board straps, debug header and pin pads around the pin block.
 assumes the bench sets the wanted strap, header and pad levels.
*/
`timescale 1ns/100ps

module gsd_board_model (
    input  wire logic       pwr_lvl_i,
    input  wire logic       dbg_lvl_i,
    input  wire logic       pst_lvl_i,
    input  wire logic [7:0] pad_i,
    input  wire logic [7:0] dut_out_i,
    input  wire logic [7:0] dut_oe_i,
    output logic            power_saving_strap_o,
    output logic            debug_enable_input_o,
    output logic            port_status_output_enable_o,
    output logic [7:0]      gpio_o
);
    // ----------------------------------------
    // straps held steady by the bench across reset
    // ----------------------------------------
    assign power_saving_strap_o        = pwr_lvl_i;
    assign debug_enable_input_o        = dbg_lvl_i;
    assign port_status_output_enable_o = pst_lvl_i;
    // ----------------------------------------
    // pad level: device drive wins where enabled, else the header level
    // ----------------------------------------
    assign gpio_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & pad_i);
endmodule

/* File: dv/gsd_pin_cfg_tb.sv */
/*
 gsd_pin_cfg_tb.sv: self-checking bench for the pin configuration block.
 assumes gsd_params.svh on the include path and the board model beside it.
*/
`timescale 1ns/100ps
`include "gsd_params.svh"

module gsd_pin_cfg_tb;
    import gsd_pkg::*;
    logic        clk_i, rst_i, pwr, dbg, pst, ps_w, de_w, pe_w;
    logic [7:0]  pad, dout, doe, pins;
    logic [2:0]  pst_in, pso, psoe;
    gsd_wb_req_t req;
    gsd_wb_rsp_t rsp;
    gsd_strap_t  strap;
    int          miscompares, check_count;

    gsd_board_model u_board (.pwr_lvl_i(pwr), .dbg_lvl_i(dbg), .pst_lvl_i(pst), .pad_i(pad),
        .dut_out_i(dout), .dut_oe_i(doe), .power_saving_strap_o(ps_w), .debug_enable_input_o(de_w),
        .port_status_output_enable_o(pe_w), .gpio_o(pins));
    gsd_pin_cfg u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .gpio_i(pins),
        .gpio_o(dout), .gpio_oe_o(doe), .power_saving_strap_i(ps_w), .debug_enable_input_i(de_w),
        .port_status_output_enable_i(pe_w), .port_status_i(pst_in), .port_status_out_o(pso),
        .port_status_out_oe_o(psoe), .strap_o(strap));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ----------------------------------------
    // classic single cycle, held until ack is sampled high
    // ----------------------------------------
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        if (rsp.ack !== 1'b1) begin
            miscompares++;
            summarize();
        end else begin
            rd = rsp.dat;
            req.cyc <= 1'b0;
            req.stb <= 1'b0;
        end
    endtask

    // straps settle well before release; synchronisers need a few cycles after
    task automatic do_reset(input logic p, input logic d, input logic [7:0] pd);
        pwr <= p;
        dbg <= d;
        pad <= pd;
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic sc_debug();
        logic [31:0] rd;
        do_reset(1'b0, 1'b0, 8'h13);
        chk(strap.pwr_save, 1'b0);
        chk(strap.debug_mode, 1'b1);
        chk(strap.debug_sel, 5'h13);
        wb(1'b0, `GSD_OFS_STRAP, 32'h0, rd);
        chk(rd, 32'h0000_1302);
        wb(1'b1, `GSD_OFS_GPIO_OE, 32'hff, rd);
        repeat (2) @(posedge clk_i);
        chk(doe, 8'he0);
        pst_in <= 3'h5;
        repeat (4) @(posedge clk_i);
        chk(psoe, 3'h0);
        pst <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(psoe, 3'h7);
        chk(pso, 3'h5);
        pst_in <= 3'h2;
        dbg <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(pso, 3'h2);
        chk(strap.debug_mode, 1'b1);
        pst <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(psoe, 3'h0);
        pst <= 1'b1;
    endtask

    task automatic sc_normal();
        logic [31:0] rd;
        do_reset(1'b1, 1'b1, 8'ha5);
        chk(strap.pwr_save, 1'b1);
        chk(strap.debug_mode, 1'b0);
        chk(strap.smb_addr, 3'h5);
        chk(psoe, 3'h0);
        // pwr bit 0, address 5 at bits 6..4, selection 5 at bits 12..8
        wb(1'b0, `GSD_OFS_STRAP, 32'h0, rd);
        chk(rd, 32'h0000_0551);
        wb(1'b1, `GSD_OFS_GPIO_OE, 32'hff, rd);
        wb(1'b1, `GSD_OFS_GPIO_OUT, 32'h3c, rd);
        wb(1'b0, `GSD_OFS_GPIO_OE, 32'h0, rd);
        chk(rd, 32'hff);
        chk(doe, 8'hff);
        chk(dout, 8'h3c);
        wb(1'b0, `GSD_OFS_GPIO_OUT, 32'h0, rd);
        chk(rd, 32'h3c);
        wb(1'b1, `GSD_OFS_CTRL, 32'h1, rd);
        repeat (2) @(posedge clk_i);
        chk(doe, 8'h1f);
        wb(1'b0, `GSD_OFS_CTRL, 32'h0, rd);
        chk(rd, 32'h1);
        wb(1'b1, `GSD_OFS_GPIO_OE, 32'h0f, rd);
        pad <= 8'h5a;
        repeat (4) @(posedge clk_i);
        wb(1'b0, `GSD_OFS_GPIO_IN, 32'h0, rd);
        chk(rd, 32'h5c);
        chk(strap.smb_addr, 3'h5);
        wb(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    initial begin
        rst_i = 1'b1;
        req = '0;
        pwr = 1'b0;
        dbg = 1'b1;
        pst = 1'b0;
        pad = 8'h00;
        pst_in = 3'h0;
        miscompares = 0;
        check_count = 0;
        @(posedge clk_i);
        sc_debug();
        sc_normal();
        summarize();
    end
endmodule
